// ### core/port_c_d_alternate_override.sv
// Purpose: pin override logic for port C and port D bits 7..4
// Assumes: aclk 10 MHz, synchronous active-low reset, AXI4-Lite slave
// Notes: test clock is sampled, so it must run well below aclk / 4
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
module port_c_d_alternate_override (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [7:0]                       awaddr,
  input  wire logic                             awvalid,
  output logic                                  awready,
  input  wire logic [31:0]                      wdata,
  input  wire logic [3:0]                       wstrb,
  input  wire logic                             wvalid,
  output logic                                  wready,
  output logic [1:0]                            bresp,
  output logic                                  bvalid,
  input  wire logic                             bready,
  input  wire logic [7:0]                       araddr,
  input  wire logic                             arvalid,
  output logic                                  arready,
  output logic [31:0]                           rdata,
  output logic [1:0]                            rresp,
  output logic                                  rvalid,
  input  wire logic                             rready,
  input  wire logic                             test_iface_enable,
  input  wire logic [7:0]                       portc_pin_in,
  input  wire logic                             portd_bit4_pin_in,
  input  wire logic                             portd_bit4_direction,
  input  wire logic                             portd_bit5_direction,
  input  wire logic [7:0]                       ext_addr_hi,
  input  wire logic                             ext_read_strobe,
  input  wire logic                             ext_write_strobe,
  input  wire logic                             timer1_compare_a_out,
  input  wire logic                             timer1_compare_a_en,
  input  wire logic                             timer3_compare_a_out,
  input  wire logic                             timer3_compare_a_en,
  input  wire logic                             usart0_clock_out,
  output pin_override_pkg::pc_override_type     portc_override,
  output pin_override_pkg::pd_override_type     portd_override,
  output logic [15:8]                           pin_change_input,
  output logic                                  usart0_sync_clock_in,
  output logic                                  timer_osc_pins_connect
);

  typedef struct packed {
    logic [7:0]                       pin_s1;
    logic [7:0]                       pin_s2;
    logic                             pd4_s1;
    logic                             pd4_s2;
    logic                             fuse_s1;
    logic                             fuse_s2;
    logic                             tck_prev;
    pin_override_pkg::tap_state_type  tap;
    logic [3:0]                       ir;
    logic                             bypass;
    logic                             tdo;
    pin_override_pkg::ctrl_type       ctrl;
    logic [7:0]                       mask;
    logic                             aw_full;
    logic [7:0]                       aw_addr;
    logic                             w_full;
    logic [7:0]                       w_data;
    logic                             w_lane0;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             rvalid;
    logic [31:0]                      rdata;
    logic [1:0]                       rresp;
    pin_override_pkg::pc_override_type pc;
    pin_override_pkg::pd_override_type pd;
    logic [7:0]                       pcint;
    logic                             xck_in;
  } state_type;

  state_type state;
  state_type next_state;

  // Reset image; fuse sampling keeps running so test pull-ups stay on
  function automatic state_type reset_image(input logic fuse_raw,
                                            input logic fuse_s1, fuse_s2);
    state_type r;
    r = '0;
    r.fuse_s1 = fuse_raw;
    r.fuse_s2 = fuse_s1;
    r.tap = pin_override_pkg::TAP_RESET;
    r.ctrl = pin_override_pkg::CTRL_RESET;
    r.mask = pin_override_pkg::MASK_RESET;
    r.pc.pullup_override_enable[7] = fuse_s2;
    r.pc.pullup_override_value[7]  = fuse_s2;
    r.pc.pullup_override_enable[5] = fuse_s2;
    r.pc.pullup_override_value[5]  = fuse_s2;
    r.pc.pullup_override_enable[4] = fuse_s2;
    r.pc.pullup_override_value[4]  = fuse_s2;
    return r;
  endfunction

  // TAP walk on the test-mode-select level; Exit2 with TMS high goes to Exit1, not Update
  function automatic pin_override_pkg::tap_state_type tap_step(
      input pin_override_pkg::tap_state_type s, input logic tms);
    pin_override_pkg::tap_state_type n;
    n = s;
    unique case (s)
      pin_override_pkg::TAP_RESET:
        n = tms ? pin_override_pkg::TAP_RESET : pin_override_pkg::TAP_IDLE;
      pin_override_pkg::TAP_IDLE, pin_override_pkg::TAP_UPD_DR,
      pin_override_pkg::TAP_UPD_IR:
        n = tms ? pin_override_pkg::TAP_SEL_DR : pin_override_pkg::TAP_IDLE;
      pin_override_pkg::TAP_SEL_DR:
        n = tms ? pin_override_pkg::TAP_SEL_IR : pin_override_pkg::TAP_CAP_DR;
      pin_override_pkg::TAP_CAP_DR, pin_override_pkg::TAP_SH_DR,
      pin_override_pkg::TAP_EX2_DR:
        n = tms ? pin_override_pkg::TAP_EX1_DR : pin_override_pkg::TAP_SH_DR;
      pin_override_pkg::TAP_EX1_DR:
        n = tms ? pin_override_pkg::TAP_UPD_DR : pin_override_pkg::TAP_PAU_DR;
      pin_override_pkg::TAP_PAU_DR:
        n = tms ? pin_override_pkg::TAP_EX2_DR : pin_override_pkg::TAP_PAU_DR;
      pin_override_pkg::TAP_SEL_IR:
        n = tms ? pin_override_pkg::TAP_RESET : pin_override_pkg::TAP_CAP_IR;
      pin_override_pkg::TAP_CAP_IR, pin_override_pkg::TAP_SH_IR,
      pin_override_pkg::TAP_EX2_IR:
        n = tms ? pin_override_pkg::TAP_EX1_IR : pin_override_pkg::TAP_SH_IR;
      pin_override_pkg::TAP_EX1_IR:
        n = tms ? pin_override_pkg::TAP_UPD_IR : pin_override_pkg::TAP_PAU_IR;
      pin_override_pkg::TAP_PAU_IR:
        n = tms ? pin_override_pkg::TAP_EX2_IR : pin_override_pkg::TAP_PAU_IR;
    endcase
    return n;
  endfunction

  logic jt;
  logic tck_rise;
  logic tck_fall;
  logic tap_instr_shift_state;
  logic tap_data_shift_state;
  logic [7:0] addr_drive;

  // Decoded test state, taken from synchronised pins only
  assign jt = state.fuse_s2;
  assign tck_rise = state.pin_s2[pin_override_pkg::TCK_BIT]
                    & ~state.tck_prev;
  assign tck_fall = ~state.pin_s2[pin_override_pkg::TCK_BIT]
                    & state.tck_prev;
  assign tap_instr_shift_state = state.tap == pin_override_pkg::TAP_SH_IR;
  assign tap_data_shift_state = state.tap == pin_override_pkg::TAP_SH_DR;

  // Per-bit address ownership against the mask threshold
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      addr_drive[k] = state.ctrl.ext_mem_enable
        & ({1'b0, state.ctrl.ext_addr_mask_field}
           < pin_override_pkg::MASK_THRESH[4*k +: 4]);
    end
  end

  // All next-state logic
  always_comb begin
    logic       wr_go;
    logic [7:0] wa;
    logic [7:0] ra;
    wr_go = 1'b0;
    wa = 8'h00;
    ra = 8'h00;
    next_state = state;
    next_state.pin_s1 = portc_pin_in;
    next_state.pin_s2 = state.pin_s1;
    next_state.pd4_s1 = portd_bit4_pin_in;
    next_state.pd4_s2 = state.pd4_s1;
    next_state.fuse_s1 = test_iface_enable;
    next_state.fuse_s2 = state.fuse_s1;
    next_state.tck_prev = state.pin_s2[pin_override_pkg::TCK_BIT];

    // TAP advances only on test clock edges; held reset when disabled
    if (!jt) begin
      next_state.tap = pin_override_pkg::TAP_RESET;
    end else if (tck_rise) begin
      next_state.tap = tap_step(state.tap,
        state.pin_s2[pin_override_pkg::TMS_BIT]);
      if (state.tap == pin_override_pkg::TAP_CAP_IR) begin
        next_state.ir = pin_override_pkg::IR_CAPTURE;
      end
      if (tap_instr_shift_state) begin
        next_state.ir = {state.pin_s2[pin_override_pkg::TDI_BIT],
                         state.ir[pin_override_pkg::IR_W-1:1]};
      end
      if (state.tap == pin_override_pkg::TAP_CAP_DR) begin
        next_state.bypass = 1'b0;
      end
      if (tap_data_shift_state) begin
        next_state.bypass = state.pin_s2[pin_override_pkg::TDI_BIT];
      end
    end
    // Serial data leaves on the falling test clock edge
    if (jt && tck_fall) begin
      next_state.tdo = tap_instr_shift_state ? state.ir[0] : state.bypass;
    end

    // Write channel: address and data taken in either order
    if (awvalid && !state.aw_full && !state.bvalid) begin
      next_state.aw_full = 1'b1;
      next_state.aw_addr = awaddr;
    end
    if (wvalid && !state.w_full && !state.bvalid) begin
      next_state.w_full = 1'b1;
      next_state.w_data = wdata[7:0];
      next_state.w_lane0 = wstrb[0];
    end
    if (state.aw_full && state.w_full) begin
      wr_go = 1'b1;
      wa = state.aw_addr;
      next_state.aw_full = 1'b0;
      next_state.w_full = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp = pin_override_pkg::RESP_OKAY;
    end
    if (wr_go && wa == pin_override_pkg::CTRL_ADDR) begin
      if (state.w_lane0) next_state.ctrl = state.w_data;
    end else if (wr_go && wa == pin_override_pkg::MASK_ADDR) begin
      if (state.w_lane0) next_state.mask = state.w_data;
    end else if (wr_go && wa != pin_override_pkg::STAT_ADDR) begin
      next_state.bresp = pin_override_pkg::RESP_SLVERR;
    end
    if (state.bvalid && bready) next_state.bvalid = 1'b0;

    // Read channel, answer one cycle after address
    if (arvalid && !state.rvalid) begin
      ra = araddr;
      next_state.rvalid = 1'b1;
      next_state.rresp = pin_override_pkg::RESP_OKAY;
      next_state.rdata = 32'h0000_0000;
      if (ra == pin_override_pkg::CTRL_ADDR) begin
        next_state.rdata[7:0] = state.ctrl;
      end else if (ra == pin_override_pkg::MASK_ADDR) begin
        next_state.rdata[7:0] = state.mask;
      end else if (ra == pin_override_pkg::STAT_ADDR) begin
        next_state.rdata[7:0] = state.pcint;
        next_state.rdata[11:8] = state.tap;
        next_state.rdata[12] = jt;
      end else begin
        next_state.rresp = pin_override_pkg::RESP_SLVERR;
      end
    end else if (state.rvalid && rready) begin
      next_state.rvalid = 1'b0;
    end

    // Port C overrides: address bus first, test pins on top
    next_state.pc.pullup_override_enable = addr_drive
      | (jt ? pin_override_pkg::TEST_PINS : 8'h00);
    next_state.pc.pullup_override_value =
      jt ? pin_override_pkg::TEST_PINS : 8'h00;
    next_state.pc.direction_override_enable = addr_drive
      | (jt ? pin_override_pkg::TEST_PINS : 8'h00);
    // Test pins in; bit 6 drives only in shift states, else pulled high
    next_state.pc.direction_override_value =
      jt ? {1'b0, tap_instr_shift_state | tap_data_shift_state, 6'h0f} : 8'hff;
    next_state.pc.out_value_override_enable = jt
      ? {1'b0, 1'b1, 6'h00} | (addr_drive & 8'h0f)
      : addr_drive;
    next_state.pc.out_value_override_value = ext_addr_hi;
    next_state.pc.out_value_override_value[pin_override_pkg::TDO_BIT] =
      jt ? state.tdo : ext_addr_hi[6];
    next_state.pc.input_en_override_enable =
      (state.ctrl.pin_change_group1_enable ? state.mask : 8'h00)
      | (jt ? pin_override_pkg::TEST_PINS : 8'h00);
    next_state.pc.input_en_override_value = 8'hff;
    next_state.pcint = state.pin_s2;

    // Port D bits 7..4
    next_state.pd.pullup_override_enable = {
      {2{state.ctrl.ext_mem_enable}},
      {2{state.ctrl.async_timer_clock_select}}};
    next_state.pd.pullup_override_value = 4'h0;
    next_state.pd.direction_override_enable =
      next_state.pd.pullup_override_enable;
    next_state.pd.direction_override_value = 4'b1100;
    next_state.pd.out_value_override_enable = {
      {2{state.ctrl.ext_mem_enable}},
      ~state.ctrl.async_timer_clock_select & timer1_compare_a_en
        & portd_bit5_direction,
      ~state.ctrl.async_timer_clock_select & portd_bit4_direction
        & (state.ctrl.usart0_sync_mode
           | timer3_compare_a_en)};
    next_state.pd.out_value_override_value = {
      ext_read_strobe, ext_write_strobe,
      timer1_compare_a_out,
      state.ctrl.usart0_sync_mode ? usart0_clock_out
                                  : timer3_compare_a_out};
    // Digital input cut while the oscillator owns the pins
    next_state.pd.input_en_override_enable = {2'b00,
      {2{state.ctrl.async_timer_clock_select}}};
    next_state.pd.input_en_override_value = 4'h0;
    next_state.xck_in = state.ctrl.usart0_sync_mode & ~portd_bit4_direction
      & ~state.ctrl.async_timer_clock_select
      & state.pd4_s2;
  end

  // Single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= reset_image(test_iface_enable, state.fuse_s1, state.fuse_s2);
    end else begin
      state <= next_state;
    end
  end

  // Outputs
  assign awready = ~state.aw_full & ~state.bvalid;
  assign wready = ~state.w_full & ~state.bvalid;
  assign bvalid = state.bvalid;
  assign bresp = state.bresp;
  assign arready = ~state.rvalid;
  assign rvalid = state.rvalid;
  assign rdata = state.rdata;
  assign rresp = state.rresp;
  assign portc_override = state.pc;
  assign portd_override = state.pd;
  assign pin_change_input = state.pcint;
  assign usart0_sync_clock_in = state.xck_in;
  assign timer_osc_pins_connect = state.ctrl.async_timer_clock_select;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tdo_shift_only: assert property (
    $past(jt) |-> state.pc.direction_override_value[6]
                  == $past(tap_instr_shift_state | tap_data_shift_state))
    else $error("test data out driven outside shift");
  a_test_pins_held: assert property (
    $past(jt) |-> &state.pc.direction_override_enable[7:4]
      && &state.pc.pullup_override_value[7:4]
      && &state.pc.input_en_override_enable[7:4])
    else $error("test pins not withheld");
  a_tms_steers_tap: assert property (
    (jt && tck_rise && state.tap == pin_override_pkg::TAP_RESET
     && !state.pin_s2[pin_override_pkg::TMS_BIT]) ##1 jt
    |-> state.tap == pin_override_pkg::TAP_IDLE)
    else $error("tms low did not leave reset state");
  a_tap_tck_only: assert property (
    (jt && !tck_rise) ##1 jt |-> $stable(state.tap))
    else $error("tap moved without test clock");
  a_tdo_select: assert property (
    $past(jt) |-> state.pc.out_value_override_enable[6]
      && state.pc.out_value_override_value[6] == $past(state.tdo))
    else $error("bit 6 not carrying test data out");
  a_addr_drive: assert property (
    $past(state.ctrl.ext_mem_enable && !jt
          && state.ctrl.ext_addr_mask_field == 3'h0)
    |-> state.pc.direction_override_enable == 8'hff
      && state.pc.out_value_override_value == $past(ext_addr_hi))
    else $error("address bits not driven");
  a_pin_change_in: assert property (
    pin_change_input == $past(portc_pin_in, 3))
    else $error("pin change input mismatch");
  a_mem_strobes: assert property (
    $past(state.ctrl.ext_mem_enable) |->
      state.pd.out_value_override_enable[3:2] == 2'b11
      && state.pd.out_value_override_value[3:2]
         == $past({ext_read_strobe, ext_write_strobe}))
    else $error("memory strobes not on port D");
  a_osc_isolate: assert property (
    $past(state.ctrl.async_timer_clock_select) |->
      state.pd.direction_override_enable[1:0] == 2'b11
      && state.pd.out_value_override_enable[1:0] == 2'b00)
    else $error("oscillator pins not isolated");
  a_cmp_needs_dir: assert property (
    state.pd.out_value_override_enable[1:0] != 2'b00 |->
      (~$past({portd_bit5_direction, portd_bit4_direction})
       & state.pd.out_value_override_enable[1:0]) == 2'b00)
    else $error("compare output without direction");
  a_pullup_reset: assert property (
    disable iff (1'b0) (!aresetn && state.fuse_s2) |=>
      state.pc.pullup_override_value[7] && state.pc.pullup_override_value[5]
      && state.pc.pullup_override_value[4])
    else $error("test pull-ups dropped in reset");

  c_tap_data_shift_state: cover property (jt && tap_data_shift_state && tck_rise);
  c_tap_instr_shift_state: cover property (jt && tap_instr_shift_state && tck_rise);
  c_addr_bus: cover property (state.ctrl.ext_mem_enable && !jt);
  c_xck_out: cover property (state.pd.out_value_override_enable[0]
                             && state.ctrl.usart0_sync_mode);

endmodule

// ### shared/pin_override_pkg.sv
// Purpose: constants and carriers for the port C/D pin override block
// Assumes: 32-bit AXI4-Lite register slave, byte addresses below
// Notes:
// Notes on behaviour
// - Test data out driven only in shift states
// - Test enable takes port C bits 7..4
// - Bit 5 pin steers the TAP state machine
// - TAP sequenced only on test clock edges
// - Bit 6 value: test data out, else address 14
// - Memory enable drives address below mask threshold
// - Input enable from pin-change mask or test enable
// - Port C inputs feed pin-change inputs 8..15
// - Port D bit 7 carries read strobe
// - Port D bit 6 carries write strobe
// - Timer oscillator select frees bit 5 from port
// - Timer oscillator select frees bit 4 from port
// - USART0 clock pin direction follows bit 4 direction
// - Timer1 compare A on bit 5 needs output direction
// - Compare A on bit 4 needs output direction
// - Test pin pull-ups on bits 7, 5 and 4 stay on during reset
package pin_override_pkg;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] MASK_ADDR = 8'h04;
  localparam logic [7:0] STAT_ADDR = 8'h08;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Address-mask thresholds, one nibble per port C bit (bit 0 lowest)
  localparam logic [31:0] MASK_THRESH = 32'h1234_5677;

  // Port C test pin positions
  localparam int TDI_BIT = 7;
  localparam int TDO_BIT = 6;
  localparam int TMS_BIT = 5;
  localparam int TCK_BIT = 4;
  localparam logic [7:0] TEST_PINS = 8'hf0;

  // Instruction register, then control and mask register reset values
  localparam int IR_W = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  typedef enum logic [3:0] {
    TAP_RESET   = 4'b0000,
    TAP_IDLE    = 4'b0001,
    TAP_SEL_DR  = 4'b0010,
    TAP_CAP_DR  = 4'b0011,
    TAP_SH_DR   = 4'b0100,
    TAP_EX1_DR  = 4'b0101,
    TAP_PAU_DR  = 4'b0110,
    TAP_EX2_DR  = 4'b0111,
    TAP_UPD_DR  = 4'b1000,
    TAP_SEL_IR  = 4'b1001,
    TAP_CAP_IR  = 4'b1010,
    TAP_SH_IR   = 4'b1011,
    TAP_EX1_IR  = 4'b1100,
    TAP_PAU_IR  = 4'b1101,
    TAP_EX2_IR  = 4'b1110,
    TAP_UPD_IR  = 4'b1111
  } tap_state_type;

  // Control register fields, bit 7 downward
  typedef struct packed {
    logic       pad;
    logic       usart0_sync_mode;
    logic       async_timer_clock_select;
    logic       pin_change_group1_enable;
    logic [2:0] ext_addr_mask_field;
    logic       ext_mem_enable;
  } ctrl_type;

  // Override set for the eight port C pins
  typedef struct packed {
    logic [7:0] pullup_override_enable;
    logic [7:0] pullup_override_value;
    logic [7:0] direction_override_enable;
    logic [7:0] direction_override_value;
    logic [7:0] out_value_override_enable;
    logic [7:0] out_value_override_value;
    logic [7:0] input_en_override_enable;
    logic [7:0] input_en_override_value;
  } pc_override_type;

  // Override set for port D bits 7..4 (index 3 is bit 7)
  typedef struct packed {
    logic [3:0] pullup_override_enable;
    logic [3:0] pullup_override_value;
    logic [3:0] direction_override_enable;
    logic [3:0] direction_override_value;
    logic [3:0] out_value_override_enable;
    logic [3:0] out_value_override_value;
    logic [3:0] input_en_override_enable;
    logic [3:0] input_en_override_value;
  } pd_override_type;

endpackage

// ### test/jtag_tester.sv
// Purpose: far-side model: test tester and port C pin levels
// Assumes: steps start just after an aclk edge
// Notes: test clock stands still between steps
module jtag_tester (
  input  wire logic       aclk,
  output logic      [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = 8'h00;
  // Phases of 5 aclk, safely above the 3-flop sampling delay
  task automatic step(input logic tms);
    @(posedge aclk);
    pins[5] <= tms;
    repeat (5) @(posedge aclk);
    pins[4] <= 1'b1;
    repeat (5) @(posedge aclk);
    pins[4] <= 1'b0;
    repeat (5) @(posedge aclk);
  endtask
  task automatic levels(input logic [7:0] v);
    @(posedge aclk);
    pins <= v;
  endtask
endmodule

// ### test/port_c_d_alternate_override_tb.sv
// Purpose: self-checking bench for the port C/D override block
// Assumes: AXI4-Lite master tasks, tester model on port C
// Notes: waits on registered outputs use the stated latencies
module port_c_d_alternate_override_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  awaddr, araddr, pins, ext_addr_hi, e;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [15:8] pin_change_input;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, osc, uci;
  logic        test_en, pd4_in, dir4, dir5, rds, wrs, uco;
  logic        t1o, t1e, t3o, t3e;
  pin_override_pkg::pc_override_type pc;
  pin_override_pkg::pd_override_type pd;
  int          n_mismatch, cmp_count;
  jtag_tester u_tester (.aclk(aclk), .pins(pins));
  port_c_d_alternate_override u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .test_iface_enable(test_en), .portc_pin_in(pins),
    .portd_bit4_pin_in(pd4_in), .portd_bit4_direction(dir4),
    .portd_bit5_direction(dir5), .ext_addr_hi(ext_addr_hi),
    .ext_read_strobe(rds), .ext_write_strobe(wrs),
    .timer1_compare_a_out(t1o), .timer1_compare_a_en(t1e),
    .timer3_compare_a_out(t3o), .timer3_compare_a_en(t3e),
    .usart0_clock_out(uco), .portc_override(pc), .portd_override(pd),
    .pin_change_input(pin_change_input), .usart0_sync_clock_in(uci),
    .timer_osc_pins_connect(osc));
  task automatic chk(input string n, input logic [31:0] s, x);
    cmp_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    awaddr <= a; wdata <= {24'h0, v}; wstrb <= 4'hf;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin aw_ok = 1; awvalid <= 0; end
      if (wvalid && wready) begin w_ok = 1; wvalid <= 0; end
    end
    do @(posedge aclk); while (!bvalid);
    chk("bresp", bresp, pin_override_pkg::RESP_OKAY);
    bready <= 0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 0;
  endtask
  always #50 aclk = ~aclk;
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #3000000;
    n_mismatch++;
    final_report();
  end
  // Main sequence
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
    wstrb = 0; test_en = 0; pd4_in = 0; dir4 = 0; dir5 = 0; rds = 1;
    wrs = 0; uco = 0; t1o = 1; t1e = 1; t3o = 1; t3e = 1;
    ext_addr_hi = 8'h5a;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(8'h0c, d, r);
    chk("unmapped_resp", r, pin_override_pkg::RESP_SLVERR);
    for (int f = 0; f < 8; f++) begin
      wr(pin_override_pkg::CTRL_ADDR, 8'(f * 2 + 1));
      for (int k = 0; k < 8; k++)
        e[k] = f < pin_override_pkg::MASK_THRESH[4*k +: 4];
      chk("addr_dir_en", pc.direction_override_enable, e);
      chk("addr_val", pc.out_value_override_value & e,
          ext_addr_hi & e);
      chk("strobes", pd.out_value_override_value[3:2],
          {rds, wrs});
    end
    wr(pin_override_pkg::MASK_ADDR, 8'h0f);
    wr(pin_override_pkg::CTRL_ADDR, 8'h10);
    rd(pin_override_pkg::MASK_ADDR, d, r);
    chk("mask_rd", d, 32'h0000_000f);
    u_tester.levels(8'h0a);
    repeat (6) @(posedge aclk);
    chk("ie_en", pc.input_en_override_enable, 8'h0f);
    chk("pc_in", pin_change_input, 8'h0a);
    wr(pin_override_pkg::CTRL_ADDR, 8'h20);
    chk("osc", {osc, pd.direction_override_enable[1:0]},
        3'h7);
    chk("osc_ie", pd.input_en_override_enable[1:0],
        2'h3);
    wr(pin_override_pkg::CTRL_ADDR, 8'h00);
    chk("cmp_off", pd.out_value_override_enable[1:0],
        2'h0);
    dir5 <= 1;
    dir4 <= 1;
    repeat (3) @(posedge aclk);
    chk("cmp_on", pd.out_value_override_enable[1:0],
        2'h3);
    wr(pin_override_pkg::CTRL_ADDR, 8'h40);
    t3o <= 0; uco <= 1;
    repeat (3) @(posedge aclk);
    chk("uclk_out", pd.out_value_override_value[0], 1'b1);
    dir4 <= 0; pd4_in <= 1;
    repeat (6) @(posedge aclk);
    chk("uclk_in", uci, 1'b1);
    test_en <= 1;
    repeat (4) @(posedge aclk);
    chk("tst_pu", {pc.pullup_override_enable[7:4],
        pc.pullup_override_value[7:4]}, 8'hff);
    chk("tst_ie", pc.input_en_override_enable[7:4],
        4'hf);
    for (int i = 0; i < 6; i++) u_tester.step(i < 5);
    rd(pin_override_pkg::STAT_ADDR, d, r);
    chk("tap_idle", d[12:0], 13'h110a);
    chk("tdo_idle", pc.direction_override_value[6], 1'b0);
    u_tester.step(1); u_tester.step(0); u_tester.step(0);
    repeat (20) @(posedge aclk);
    rd(pin_override_pkg::STAT_ADDR, d, r);
    chk("tap_shdr", d[11:8], 4'h4);
    chk("tdo_drive", pc.direction_override_value[6],
        1'b1);
    chk("tdo_sel", pc.out_value_override_enable[6], 1'b1);
    aresetn <= 0;
    repeat (4) @(posedge aclk);
    chk("rst_pu", {pc.pullup_override_enable[7],
        pc.pullup_override_enable[5:4]}, 3'h7);
    aresetn <= 1;
    final_report();
  end
endmodule
